/* rtl/flash_status_map.svh */
/*
 * Register offsets, field positions, reset values and limits of the
 * flash status register bank.
 * Assumes a 3-bit register address and 8-bit register data.
 */
`ifndef FLASH_STATUS_MAP_SVH
`define FLASH_STATUS_MAP_SVH

// register offsets on the software port
`define OFF_S1_LIVE 3'h0
`define OFF_S1_SAVED 3'h1
`define OFF_S2_LIVE 3'h2
`define OFF_CFG_ONE 3'h3
`define OFF_GUARD_OPT 3'h4

// status register one fields
`define S1_PFAIL 6
`define S1_EFAIL 5
`define S1_LBP_HI 4
`define S1_LBP_LO 2
`define S1_WEL 1
`define S1_BUSY 0

// status register two fields
`define S2_CRCS 4
`define S2_CRCA 3
`define S2_SERES 2
`define S2_ERSS 1
`define S2_PRGS 0

// config register one fields
`define CFG_GUARD_HI 6
`define CFG_GUARD_LO 2
`define CFG_TB 5
`define CFG_PLOCK 4
`define CFG_MASK 8'h74

// reset values
`define S1_SAVED_RST 3'h0
`define CFG_RST 8'h00
`define GOPT_RST 3'h7

// least span between crc start and end address
`define CRC_MIN_SPAN 3

`endif

/* rtl/flash_status_pkg.sv */
/*
 * Types shared by the flash status register bank.
 * Assumes the map header supplies all numeric constants.
 */
package flash_status_pkg;

	// transactions arriving from the link decoder
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_SET_WEL,
		CMD_RESET_WEL,
		CMD_CLR_FAIL,
		CMD_EVAL_ERASE,
		CMD_SOFT_RESET
	} link_cmd_t;

	// embedded operation kinds
	typedef enum logic [1:0] {
		OP_PROGRAM,
		OP_ERASE,
		OP_REG_WRITE,
		OP_CRC
	} op_kind_t;

	// embedded operation tracker
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_SUSPEND,
		ST_FAIL_HOLD
	} op_state_t;

endpackage

/* rtl/sync2.sv */
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes each bit is a level that is stable for several clk_sys cycles.
 */
`timescale 1ns/100ps

module sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [WIDTH-1:0] d, // asynchronous levels
	output logic [WIDTH-1:0] q // synchronised levels
);

	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule

/* rtl/guard_decode.sv */
/*
 * Legacy block guard decode: is a sector inside the guarded portion.
 * Assumes a power-of-two sector count of 2**SECT_W.
 */
`timescale 1ns/100ps

module guard_decode #(
	parameter int SECT_W = 9
) (
	input wire logic [2:0] guard_size, // legacy block guard size code
	input wire logic from_bottom, // 1 guards from the bottom
	input wire logic [SECT_W-1:0] sector, // sector under test
	output logic guarded // sector is guarded
);

	logic [SECT_W:0] all_sect;
	logic [SECT_W:0] span;
	logic [SECT_W:0] sect_ext;

	// 001 is one sixty-fourth, each step doubles, 111 is everything
	always_comb begin
		all_sect = {1'b1, {SECT_W{1'b0}}};
		sect_ext = {1'b0, sector};
		span = (guard_size == 3'h0) ? '0 : (all_sect >> (3'h7 - guard_size));
		if (from_bottom) begin
			guarded = (sect_ext < span);
		end else begin
			guarded = (sect_ext >= (all_sect - span));
		end
	end

endmodule

/* rtl/flash_status_regs.sv */
/*
 * Status registers one and two of a serial flash, with write latch,
 * failure flags, busy tracking, suspend and crc result flags.
 * Assumes a link decoder presenting transactions as levels sampled on
 * the link clock, and an embedded engine on clk_sys handshaking ops.
 */
`timescale 1ns/100ps
`include "flash_status_map.svh"

module flash_status_regs import flash_status_pkg::*; #(
	parameter int SECT_W = 9,
	parameter int ADDR_W = 32
) (
	input wire logic clk_sys, // system clock, 20 MHz
	input wire logic rst_n, // hardware reset, active low
	input wire logic [2:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic link_clk, // link clock pin
	input wire logic link_cmd_valid, // transaction present on link
	input wire logic [2:0] link_cmd, // transaction code
	input wire logic op_start, // engine asks to start an op
	input wire logic [1:0] op_kind, // kind of op asked for
	input wire logic [SECT_W-1:0] op_sector, // target sector
	input wire logic [ADDR_W-1:0] crc_start_address, // crc first address
	input wire logic [ADDR_W-1:0] crc_end_address, // crc last address
	input wire logic op_done, // engine finished the op
	input wire logic op_fail, // finished op failed
	input wire logic op_suspend, // engine suspended the op
	input wire logic op_resume, // engine resumed the op
	input wire logic integrity_fail, // boot or config integrity failed
	input wire logic erase_ok, // addressed sector erased fully
	output logic op_go, // op accepted, one-cycle pulse
	output logic op_refused, // op refused, one-cycle pulse
	output logic device_busy_flag, // busy level
	output logic write_enable_latch // write latch level
);

	op_state_t state_r;
	op_kind_t cur_kind_r;
	logic program_fail_flag_r, erase_fail_flag_r, wel_r;
	logic [2:0] lbp_live_r, lbp_saved_r;
	logic [7:0] cfg_r;
	logic [2:0] gopt_r;
	logic crca_r, seres_r, lclk_prev_r, go_r, refused_r;
	logic [4:0] link_q;
	logic cmd_take, clr_fail, soft_rst, guarded;
	link_cmd_t cmd;
	op_kind_t kind_in;
	logic start_ok, start_guard, crc_abort, done_ok, done_bad;
	logic reg_wr_ok, cfg_guard_fail, lbp_write, pfail_set, efail_set;
	logic [ADDR_W:0] crc_floor;
	logic [7:0] status_one_live, status_one_saved, status_two_live;

	// link pins are synchronised together; code is stable around edges
	sync2 #(
		.WIDTH(5)
	) u_link_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d({link_clk, link_cmd_valid, link_cmd}),
		.q(link_q)
	);

	// rising edge of the synchronised link clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lclk_prev_r <= 1'b0;
		end else begin
			lclk_prev_r <= link_q[4];
		end
	end

	assign cmd_take = link_q[4] & ~lclk_prev_r & link_q[3];
	assign cmd = link_cmd_t'(link_q[2:0]);
	assign clr_fail = cmd_take & (cmd == CMD_CLR_FAIL);
	assign soft_rst = cmd_take & (cmd == CMD_SOFT_RESET);

	guard_decode #(
		.SECT_W(SECT_W)
	) u_guard (
		.guard_size(lbp_live_r),
		.from_bottom(cfg_r[`CFG_TB]),
		.sector(op_sector),
		.guarded(guarded)
	);

	// operation acceptance and completion events
	assign kind_in = op_kind_t'(op_kind);
	assign start_ok = op_start & (state_r == ST_IDLE) & (kind_in == OP_CRC | wel_r);
	assign start_guard = start_ok & guarded & (kind_in == OP_PROGRAM | kind_in == OP_ERASE);
	assign crc_floor = {1'b0, crc_start_address} + (ADDR_W+1)'(`CRC_MIN_SPAN);
	assign crc_abort = start_ok & (kind_in == OP_CRC) & ({1'b0, crc_end_address} < crc_floor);
	assign done_ok = (state_r == ST_RUN) & op_done & ~op_fail & ~integrity_fail;
	assign done_bad = (state_r == ST_RUN) & op_done & op_fail & (cur_kind_r != OP_CRC); // crc has no fail flag

	// software writes except to guard options execute only with the latch set and no op running
	assign reg_wr_ok = reg_wr & wel_r & (state_r == ST_IDLE);
	assign cfg_guard_fail = reg_wr_ok & (reg_addr == `OFF_CFG_ONE) & ~(gopt_r[2] & gopt_r[1])
		& (reg_wdata[`CFG_GUARD_HI:`CFG_GUARD_LO] != cfg_r[`CFG_GUARD_HI:`CFG_GUARD_LO]);
	assign lbp_write = reg_wr_ok & ~cfg_r[`CFG_PLOCK]
		& (reg_addr == `OFF_S1_LIVE | reg_addr == `OFF_S1_SAVED);

	// fail causes; integrity failure raises both flags
	assign pfail_set = (start_guard & kind_in == OP_PROGRAM) | (done_bad & cur_kind_r == OP_PROGRAM)
		| cfg_guard_fail | integrity_fail;
	assign efail_set = (start_guard & kind_in == OP_ERASE)
		| (done_bad & (cur_kind_r == OP_ERASE | cur_kind_r == OP_REG_WRITE))
		| integrity_fail;

	// operation tracker; a failed op stays busy until flags clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else if (soft_rst) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (start_guard | cfg_guard_fail | integrity_fail) begin
						state_r <= ST_FAIL_HOLD;
					end else if (start_ok & ~crc_abort) begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (done_bad | integrity_fail) begin
						state_r <= ST_FAIL_HOLD;
					end else if (op_done) begin
						state_r <= ST_IDLE;
					end else if (op_suspend & cur_kind_r != OP_REG_WRITE) begin
						state_r <= ST_SUSPEND;
					end
				end
				ST_SUSPEND: begin
					if (integrity_fail) begin
						state_r <= ST_FAIL_HOLD;
					end else if (op_resume) begin
						state_r <= ST_RUN;
					end
				end
				ST_FAIL_HOLD: begin
					if (clr_fail & ~integrity_fail) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// kind of the op in flight and the start handshake pulses
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cur_kind_r <= OP_PROGRAM;
			go_r <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			if (start_ok) begin
				cur_kind_r <= kind_in;
			end
			go_r <= start_ok & ~start_guard & ~crc_abort & ~integrity_fail & ~soft_rst & ~cfg_guard_fail;
			refused_r <= op_start & ~start_ok;
		end
	end

	// sticky fail flags; a set in the clearing cycle wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			program_fail_flag_r <= 1'b0;
			erase_fail_flag_r <= 1'b0;
		end else if (soft_rst) begin
			program_fail_flag_r <= 1'b0;
			erase_fail_flag_r <= 1'b0;
		end else begin
			program_fail_flag_r <= pfail_set | (program_fail_flag_r & ~clr_fail);
			erase_fail_flag_r <= efail_set | (erase_fail_flag_r & ~clr_fail);
		end
	end

	// write latch: command sets, command or completion clears
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wel_r <= 1'b0;
		end else if (soft_rst) begin
			wel_r <= 1'b0;
		end else if (cmd_take & cmd == CMD_SET_WEL) begin
			wel_r <= 1'b1;
		end else if (cmd_take & cmd == CMD_RESET_WEL) begin
			wel_r <= 1'b0;
		end else if ((done_ok & cur_kind_r != OP_CRC) | (reg_wr_ok & ~cfg_guard_fail
			& reg_addr != `OFF_S2_LIVE & reg_addr != `OFF_GUARD_OPT)) begin
			wel_r <= 1'b0;
		end
	end

	// guard size copies; software reset reloads live from saved
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lbp_saved_r <= `S1_SAVED_RST;
			lbp_live_r <= `S1_SAVED_RST;
		end else if (soft_rst) begin
			lbp_live_r <= lbp_saved_r;
		end else if (lbp_write) begin
			lbp_live_r <= reg_wdata[`S1_LBP_HI:`S1_LBP_LO];
			if (reg_addr == `OFF_S1_SAVED) begin
				lbp_saved_r <= reg_wdata[`S1_LBP_HI:`S1_LBP_LO];
			end
		end
	end

	// config one: lock bit is one-way, locked fields frozen
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= `CFG_RST;
		end else if (reg_wr_ok & ~cfg_guard_fail & reg_addr == `OFF_CFG_ONE & ~cfg_r[`CFG_PLOCK]) begin
			cfg_r <= reg_wdata & `CFG_MASK;
		end
	end

	// guard option bits need no latch; they only gate config writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gopt_r <= `GOPT_RST;
		end else if (reg_wr & reg_addr == `OFF_GUARD_OPT) begin
			gopt_r <= reg_wdata[2:0];
		end
	end

	// crc abort flag: short range sets, next valid start clears
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			crca_r <= 1'b0;
		end else if (soft_rst) begin
			crca_r <= 1'b0;
		end else if (crc_abort) begin
			crca_r <= 1'b1;
		end else if (start_ok & kind_in == OP_CRC) begin
			crca_r <= 1'b0;
		end
	end

	// sector erase result loads on the evaluate command when idle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seres_r <= 1'b0;
		end else if (soft_rst) begin
			seres_r <= 1'b0;
		end else if (cmd_take & cmd == CMD_EVAL_ERASE & state_r == ST_IDLE) begin
			seres_r <= erase_ok;
		end
	end

	// live register images
	always_comb begin
		status_one_live = 8'h00;
		status_one_live[`S1_PFAIL] = program_fail_flag_r;
		status_one_live[`S1_EFAIL] = erase_fail_flag_r;
		status_one_live[`S1_LBP_HI:`S1_LBP_LO] = lbp_live_r;
		status_one_live[`S1_WEL] = wel_r;
		status_one_live[`S1_BUSY] = device_busy_flag;
		status_one_saved = 8'h00;
		status_one_saved[`S1_LBP_HI:`S1_LBP_LO] = lbp_saved_r;
		status_two_live = 8'h00;
		status_two_live[`S2_CRCS] = (state_r == ST_SUSPEND) & (cur_kind_r == OP_CRC);
		status_two_live[`S2_CRCA] = crca_r;
		status_two_live[`S2_SERES] = seres_r;
		status_two_live[`S2_ERSS] = (state_r == ST_SUSPEND) & (cur_kind_r == OP_ERASE);
		status_two_live[`S2_PRGS] = (state_r == ST_SUSPEND) & (cur_kind_r == OP_PROGRAM);
	end

	// read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`OFF_S1_LIVE: reg_rdata <= status_one_live;
				`OFF_S1_SAVED: reg_rdata <= status_one_saved;
				`OFF_S2_LIVE: reg_rdata <= status_two_live;
				`OFF_CFG_ONE: reg_rdata <= cfg_r;
				`OFF_GUARD_OPT: reg_rdata <= {5'h00, gopt_r};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// suspended ops are not busy; a failed op is
	assign device_busy_flag = (state_r == ST_RUN) | (state_r == ST_FAIL_HOLD);
	assign write_enable_latch = wel_r;
	assign op_go = go_r;
	assign op_refused = refused_r;

	fail_keeps_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(program_fail_flag_r | erase_fail_flag_r) |-> device_busy_flag)
		else $error("fail flag set while not busy");

	efail_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		erase_fail_flag_r & ~clr_fail & ~soft_rst |=> erase_fail_flag_r)
		else $error("erase fail flag dropped without clear");

	no_standby_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		erase_fail_flag_r & ~clr_fail & ~soft_rst |=> state_r == ST_FAIL_HOLD)
		else $error("left fail hold with erase fail set");

	guarded_erase_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start_ok & guarded & kind_in == OP_ERASE & ~soft_rst |=> erase_fail_flag_r & ~op_go)
		else $error("guarded erase not flagged");

	wel_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmd_take & cmd == CMD_SET_WEL |=> write_enable_latch)
		else $error("set latch command ignored");

	wel_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		done_ok & cur_kind_r != OP_CRC & ~(cmd_take & cmd == CMD_SET_WEL) |=> ~write_enable_latch)
		else $error("latch kept after completion");

	no_wel_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_start & ~wel_r & kind_in != OP_CRC |=> op_refused & ~op_go)
		else $error("op started without latch");

	lock_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg_r[`CFG_PLOCK] & ~soft_rst |=> $stable(lbp_live_r) & $stable(lbp_saved_r))
		else $error("guard size changed while locked");

	crc_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		crc_abort & ~soft_rst & ~integrity_fail & ~cfg_guard_fail |=> crca_r & ~device_busy_flag)
		else $error("short crc range not aborted");

	s2_reserved_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd & reg_addr == `OFF_S2_LIVE |=> reg_rdata[7:5] == 3'h0)
		else $error("status two reserved bits set");

endmodule

/* sim/link_host.sv */
/*
 * Behavioural host controller on the far side of the link: frames one
 * transaction code per link clock rise.
 * Assumes the bank samples link_clk on a much faster clk_sys.
 */
`timescale 1ns/100ps

module link_host import flash_status_pkg::*; (
	output logic link_clk, // link clock, still between frames
	output logic link_cmd_valid, // transaction present
	output logic [2:0] link_cmd // transaction code
);
	// idle: clock parked low, code lines scrambled so nothing stale is seen
	initial begin
		link_clk = 1'b0;
		link_cmd_valid = 1'b0;
		link_cmd = 3'h7;
	end

	// one frame of 800 ns; code held well before and after the rise
	// host sets the latch before operations and clears fails itself
	task automatic send(input link_cmd_t c);
		link_cmd_valid = 1'b1;
		link_cmd = c;
		#200 link_clk = 1'b1;
		#200 link_clk = 1'b0;
		#200 link_cmd_valid = 1'b0;
		link_cmd = ~c;
		// idle gap so a following frame never re-drives a line in the same step
		#200;
	endtask
endmodule

/* sim/flash_status_regs_tb.sv */
/*
 * Self-checking bench for the flash status register bank.
 * Assumes the design's map header and package; link traffic comes from link_host.
 */
`timescale 1ns/100ps
`include "flash_status_map.svh"

module flash_status_regs_tb import flash_status_pkg::*;;
	logic clk_sys, rst_n, reg_wr, reg_rd, link_clk, link_cmd_valid, op_fail, erase_ok;
	logic op_start, op_done, op_suspend, op_resume, integrity_fail;
	logic op_go, op_refused, device_busy_flag, write_enable_latch;
	logic [2:0] reg_addr, link_cmd;
	logic [7:0] reg_wdata, reg_rdata;
	logic [1:0] op_kind;
	logic [8:0] op_sector;
	logic [31:0] crc_start_address, crc_end_address;
	logic [4:0] pls;
	int fail_count, checks_done, cyc;
	op_kind_t kinds[3] = '{OP_ERASE, OP_PROGRAM, OP_CRC};
	logic [7:0] susp[3] = '{8'h02, 8'h01, 8'h10};

	assign {integrity_fail, op_resume, op_suspend, op_done, op_start} = pls;

	link_host host (.link_clk(link_clk), .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd));

	flash_status_regs uut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.link_clk, .link_cmd_valid, .link_cmd, .op_start, .op_kind, .op_sector, .crc_start_address,
		.crc_end_address, .op_done, .op_fail, .op_suspend, .op_resume, .integrity_fail, .erase_ok,
		.op_go, .op_refused, .device_busy_flag, .write_enable_latch);

	// 20 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard: the whole run needs well under this many cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe, so sample there
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk($sformatf("register %0d", a), e, reg_rdata & m);
	endtask

	// one-cycle pulse on the engine inputs; outputs settled on return
	task automatic pulse(input logic [4:0] v);
		@(posedge clk_sys);
		pls <= v;
		@(posedge clk_sys);
		pls <= 5'h00;
		#1;
	endtask

	initial begin
		{rst_n, reg_wr, reg_rd, op_fail, erase_ok, pls, cyc, fail_count, checks_done} = '0;
		{reg_addr, reg_wdata, op_kind, op_sector, crc_start_address, crc_end_address} = '0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		// reset values, reserved and unmapped places
		rd(`OFF_S1_LIVE, 8'hFF, 8'h00);
		rd(`OFF_S1_SAVED, 8'hFF, 8'h00);
		rd(`OFF_S2_LIVE, 8'hFF, 8'h00);
		rd(`OFF_GUARD_OPT, 8'hFF, 8'h07);
		rd(3'h5, 8'hFF, 8'h00);
		// no latch: writes and ops refused
		wr(`OFF_S1_SAVED, 8'h04);
		rd(`OFF_S1_SAVED, 8'hFF, 8'h00);
		op_kind <= OP_ERASE;
		pulse(5'h01);
		chk("refused", 8'h01, {7'h0, op_refused});
		host.send(CMD_SET_WEL);
		rd(`OFF_S1_LIVE, 8'hFF, 8'h02);
		host.send(CMD_RESET_WEL);
		chk("latch", 8'h00, {7'h0, write_enable_latch});
		// guard size 001, top sixty-fourth: sectors 504..511
		host.send(CMD_SET_WEL);
		wr(`OFF_S1_SAVED, 8'h04);
		rd(`OFF_S1_SAVED, 8'hFF, 8'h04);
		rd(`OFF_S1_LIVE, 8'hFF, 8'h04);
		host.send(CMD_SET_WEL);
		op_sector <= 9'd511;
		pulse(5'h01);
		chk("go", 8'h00, {7'h0, op_go});
		rd(`OFF_S1_LIVE, 8'hFD, 8'h25);
		pulse(5'h01);
		chk("refused", 8'h01, {7'h0, op_refused});
		host.send(CMD_RESET_WEL);
		rd(`OFF_S1_LIVE, 8'hFD, 8'h25);
		host.send(CMD_CLR_FAIL);
		rd(`OFF_S1_LIVE, 8'hFD, 8'h04);
		// just below the guarded portion: runs, then finishes cleanly
		host.send(CMD_SET_WEL);
		op_sector <= 9'd503;
		pulse(5'h01);
		chk("go busy", 8'h03, {6'h0, op_go, device_busy_flag});
		pulse(5'h02);
		rd(`OFF_S1_LIVE, 8'hFF, 8'h04);
		// failing erase holds busy; soft reset clears flag and latch
		host.send(CMD_SET_WEL);
		pulse(5'h01);
		op_fail <= 1'b1;
		pulse(5'h02);
		op_fail <= 1'b0;
		rd(`OFF_S1_LIVE, 8'hFD, 8'h25);
		host.send(CMD_SOFT_RESET);
		rd(`OFF_S1_LIVE, 8'hFF, 8'h04);
		// program failure, guarded program, integrity failure
		host.send(CMD_SET_WEL);
		op_kind <= OP_PROGRAM;
		op_sector <= 9'd0;
		pulse(5'h01);
		op_fail <= 1'b1;
		pulse(5'h02);
		op_fail <= 1'b0;
		rd(`OFF_S1_LIVE, 8'hFD, 8'h45);
		host.send(CMD_CLR_FAIL);
		host.send(CMD_SET_WEL);
		op_sector <= 9'd504;
		pulse(5'h01);
		rd(`OFF_S1_LIVE, 8'hFD, 8'h45);
		host.send(CMD_CLR_FAIL);
		pulse(5'h10);
		rd(`OFF_S1_LIVE, 8'hFD, 8'h65);
		host.send(CMD_CLR_FAIL);
		// register write: suspend ignored, evaluate ignored while busy, failure sets erase fail
		host.send(CMD_SET_WEL);
		op_kind <= OP_REG_WRITE;
		pulse(5'h01);
		pulse(5'h04);
		erase_ok <= 1'b1;
		host.send(CMD_EVAL_ERASE);
		erase_ok <= 1'b0;
		rd(`OFF_S2_LIVE, 8'hFF, 8'h00);
		op_fail <= 1'b1;
		pulse(5'h02);
		op_fail <= 1'b0;
		rd(`OFF_S1_LIVE, 8'hFD, 8'h25);
		host.send(CMD_CLR_FAIL);
		// suspend flags for each suspendable kind; crc span exactly 3
		crc_end_address <= 32'h0000_0003;
		op_sector <= 9'd0;
		for (int i = 0; i < 3; i++) begin
			host.send(CMD_SET_WEL);
			op_kind <= kinds[i];
			pulse(5'h01);
			pulse(5'h04);
			rd(`OFF_S2_LIVE, 8'hFF, susp[i]);
			pulse(5'h08);
			rd(`OFF_S2_LIVE, 8'hFF, 8'h00);
			pulse(5'h02);
		end
		// crc range one short aborts, a valid range clears the abort
		crc_start_address <= 32'h0000_0064;
		crc_end_address <= 32'h0000_0066;
		pulse(5'h01);
		chk("go", 8'h00, {7'h0, op_go});
		rd(`OFF_S2_LIVE, 8'hFF, 8'h08);
		rd(`OFF_S1_LIVE, 8'hFD, 8'h04);
		crc_end_address <= 32'h0000_0067;
		pulse(5'h01);
		chk("go", 8'h01, {7'h0, op_go});
		rd(`OFF_S2_LIVE, 8'hFF, 8'h00);
		op_fail <= 1'b1;
		pulse(5'h02);
		op_fail <= 1'b0;
		rd(`OFF_S1_LIVE, 8'hFD, 8'h04);
		// sector erase result after evaluate
		erase_ok <= 1'b1;
		host.send(CMD_EVAL_ERASE);
		rd(`OFF_S2_LIVE, 8'hFF, 8'h04);
		erase_ok <= 1'b0;
		host.send(CMD_EVAL_ERASE);
		rd(`OFF_S2_LIVE, 8'hFF, 8'h00);
		// bottom placement: top sector free, sector 0 guarded
		host.send(CMD_SET_WEL);
		wr(`OFF_CFG_ONE, 8'h20);
		rd(`OFF_CFG_ONE, `CFG_MASK, 8'h20);
		host.send(CMD_SET_WEL);
		op_kind <= OP_ERASE;
		op_sector <= 9'd511;
		pulse(5'h01);
		chk("go", 8'h01, {7'h0, op_go});
		pulse(5'h02);
		host.send(CMD_SET_WEL);
		op_sector <= 9'd0;
		pulse(5'h01);
		rd(`OFF_S1_LIVE, 8'hFD, 8'h25);
		host.send(CMD_CLR_FAIL);
		// guarded config change with advanced options cleared
		wr(`OFF_GUARD_OPT, 8'h01);
		host.send(CMD_SET_WEL);
		wr(`OFF_CFG_ONE, 8'h24);
		rd(`OFF_S1_LIVE, 8'hFD, 8'h45);
		host.send(CMD_CLR_FAIL);
		wr(`OFF_GUARD_OPT, 8'h07);
		// live-only guard size 111 guards every sector; soft reset reloads the saved size
		host.send(CMD_SET_WEL);
		wr(`OFF_S1_LIVE, 8'h1C);
		host.send(CMD_SET_WEL);
		pulse(5'h01);
		rd(`OFF_S1_LIVE, 8'hFD, 8'h3D);
		rd(`OFF_S1_SAVED, 8'hFF, 8'h04);
		host.send(CMD_SOFT_RESET);
		rd(`OFF_S1_LIVE, 8'hFF, 8'h04);
		// permanent lock freezes the guard size field
		host.send(CMD_SET_WEL);
		wr(`OFF_CFG_ONE, 8'h30);
		rd(`OFF_CFG_ONE, `CFG_MASK, 8'h30);
		host.send(CMD_SET_WEL);
		wr(`OFF_S1_SAVED, 8'h1C);
		rd(`OFF_S1_SAVED, 8'hFF, 8'h04);
		rd(`OFF_S1_LIVE, 8'h1C, 8'h04);
		finish_test();
	end
endmodule
